// ==== logic/ir_pin_pkg.sv ====
/*
  Constants for the infrared transceiver pin control block: APB register
  offsets, bit positions and reset values.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package ir_pin_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_XCVR_CTRL  = 8'h00;
  localparam logic [7:0] OFF_XCVR_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_IR_CFG3    = 8'h08;
  localparam logic [7:0] OFF_TX_DATA    = 8'h0C;
  localparam logic [7:0] OFF_RX_STATUS  = 8'h10;

  // Transceiver control register fields.
  localparam int BIT_GPIO_D    = 0;
  localparam int BIT_TX_FORCE  = 1;
  localparam int BIT_PWR_OFF   = 4;
  localparam int BIT_GPIO_C    = 5;
  localparam int BIT_GPIO_B    = 6;
  localparam int BIT_GPIO_A    = 7;

  // Transceiver control 2 register fields.
  localparam int BIT_RX1_INV   = 0;
  localparam int BIT_RX2_INV   = 1;

  // Configuration 3 register fields.
  localparam int BIT_DET_LEVEL = 4;

  // Receive status register fields.
  localparam int BIT_RX1_PULSE = 0;
  localparam int BIT_RX2_PULSE = 1;

  // Reset values. Force and power-off start cleared.
  localparam logic [7:0] RST_XCVR_CTRL  = 8'h00;
  localparam logic [7:0] RST_XCVR_CTRL2 = 8'h00;
  localparam logic       RST_TX_DATA    = 1'b0;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 3;

endpackage

// ==== logic/pin_sync.sv ====
/*
  Three-flop synchroniser with agreement filter for one pin input.
  Assumes the pin is asynchronous to clk_sys; output changes only when the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import ir_pin_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Pin and result.
  input  wire logic pin_in,
  output logic      pin_sync_out
);

  logic [SYNC_STAGES-1:0] stage_q;
  logic [SYNC_STAGES-1:0] stage_d;
  logic                   level_q;
  logic                   level_d;

  always_comb begin
    stage_d = {stage_q[SYNC_STAGES-2:0], pin_in};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage_q <= {SYNC_STAGES{RESET_VALUE}};
      level_q <= RESET_VALUE;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign pin_sync_out = level_q;

endmodule
`default_nettype wire

// ==== logic/ir_transceiver_pin_control.sv ====
/*
  Pin-level control between an infrared controller and an external optical
  transceiver: transmit pair, two receive inputs, power-off and detect,
  four general-purpose outputs, with APB registers.
  Assumes one 10 MHz clock clk_sys and asynchronous active-low resetn.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_pin_control
  import ir_pin_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial data from the modulator.
  input  wire logic        tx_serial,
  // Transceiver pins.
  output logic             ir_tx_out,
  output logic             ir_tx_out_n,
  input  wire logic        ir_rx_in_first,
  input  wire logic        ir_rx_in_second,
  output logic             optic_power_off,
  input  wire logic        optic_present_n,
  // General-purpose pins.
  output logic             gpio_a,
  output logic             gpio_b,
  output logic             gpio_c,
  output logic             gpio_d,
  // Receive pulses toward the demodulator, high means a pulse.
  output logic             rx_pulse_first,
  output logic             rx_pulse_second
);

  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  ctrl2_q;
  logic [7:0]  ctrl2_d;
  logic        swtx_q;
  logic        swtx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        txo_q;
  logic        txo_d;
  logic        poff_q;
  logic        poff_d;
  logic [3:0]  gp_q;
  logic [3:0]  gp_d;
  logic [1:0]  rxp_q;
  logic [1:0]  rxp_d;
  logic        rx1_s;
  logic        rx2_s;
  logic        det_s;
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;

  // Detect resets high so the transceiver stays off until seen present.
  pin_sync #(.RESET_VALUE(1'b1)) u_det_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_in       (optic_present_n),
    .pin_sync_out (det_s)
  );

  pin_sync #(.RESET_VALUE(1'b1)) u_rx1_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_in       (ir_rx_in_first),
    .pin_sync_out (rx1_s)
  );

  pin_sync #(.RESET_VALUE(1'b1)) u_rx2_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_in       (ir_rx_in_second),
    .pin_sync_out (rx2_s)
  );

  // Merges the written byte lane 0 into an eight-bit register.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? wd[7:0] : old_v;
  endfunction

  // Maps a raw receive level to a pulse flag under the invert bit.
  function automatic logic pulse_of(input logic lvl, input logic inv);
    pulse_of = inv ? lvl : ~lvl;
  endfunction

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = setup & ~pwrite;

  always_comb begin
    ctrl_d  = ctrl_q;
    ctrl2_d = ctrl2_q;
    swtx_d  = swtx_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d = 1'b0;
      if (paddr == OFF_XCVR_CTRL) begin
        rdata_d = {24'h00_0000, ctrl_q};
      end else if (paddr == OFF_XCVR_CTRL2) begin
        rdata_d = {24'h00_0000, ctrl2_q};
      end else if (paddr == OFF_IR_CFG3) begin
        rdata_d = 32'h0000_0000;
        rdata_d[BIT_DET_LEVEL] = det_s;
      end else if (paddr == OFF_TX_DATA) begin
        rdata_d = {31'h0000_0000, swtx_q};
      end else if (paddr == OFF_RX_STATUS) begin
        rdata_d = {30'h0000_0000, rxp_q};
      end else begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b1;
      end
      if (!rd_acc) begin
        rdata_d = 32'h0000_0000;
      end
    end
    if (wr_acc) begin
      if (paddr == OFF_XCVR_CTRL) begin
        ctrl_d = merge_byte(ctrl_q, pwdata, pstrb);
      end else if (paddr == OFF_XCVR_CTRL2) begin
        ctrl2_d = merge_byte(ctrl2_q, pwdata, pstrb);
      end else if (paddr == OFF_TX_DATA) begin
        if (pstrb[0]) begin
          swtx_d = pwdata[0];
        end
      end
    end
  end

  always_comb begin
    // The modulator lights the emitter; the force bit overrides.
    txo_d = tx_serial | swtx_q | ctrl_q[BIT_TX_FORCE];
    // Absent transceiver wins over the software bit.
    poff_d = det_s | ctrl_q[BIT_PWR_OFF];
    gp_d = {ctrl_q[BIT_GPIO_A], ctrl_q[BIT_GPIO_B],
            ctrl_q[BIT_GPIO_C], ctrl_q[BIT_GPIO_D]};
    rxp_d = {pulse_of(rx2_s, ctrl2_q[BIT_RX2_INV]),
             pulse_of(rx1_s, ctrl2_q[BIT_RX1_INV])};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= RST_XCVR_CTRL;
      ctrl2_q <= RST_XCVR_CTRL2;
      swtx_q  <= RST_TX_DATA;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      txo_q   <= 1'b0;
      poff_q  <= 1'b1;
      gp_q    <= 4'h0;
      rxp_q   <= 2'b00;
    end else begin
      ctrl_q  <= ctrl_d;
      ctrl2_q <= ctrl2_d;
      swtx_q  <= swtx_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      txo_q   <= txo_d;
      poff_q  <= poff_d;
      gp_q    <= gp_d;
      rxp_q   <= rxp_d;
    end
  end

  // Access phase always completes in one cycle.
  assign pready          = 1'b1;
  assign pslverr         = psel & penable & err_q;
  assign prdata          = rdata_q;
  assign ir_tx_out       = txo_q;
  assign ir_tx_out_n     = ~txo_q;
  assign optic_power_off = poff_q;
  assign gpio_a          = gp_q[3];
  assign gpio_b          = gp_q[2];
  assign gpio_c          = gp_q[1];
  assign gpio_d          = gp_q[0];
  assign rx_pulse_first  = rxp_q[0];
  assign rx_pulse_second = rxp_q[1];

endmodule
`default_nettype wire

// ==== tb/ir_pin_monitor.sv ====
/* Port checker for the infrared pin control block.
   Assumes a bind onto ir_transceiver_pin_control. */
`timescale 1ns/1ps
`default_nettype none
module ir_pin_monitor (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins.
  input wire logic        tx_serial,
  input wire logic        ir_tx_out,
  input wire logic        ir_tx_out_n,
  input wire logic        optic_power_off,
  input wire logic        optic_present_n,
  input wire logic        gpio_a,
  input wire logic        gpio_b,
  input wire logic        gpio_c,
  input wire logic        gpio_d
);
  logic wr0;
  assign wr0 = psel && penable && pwrite && paddr == 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence absent_s; optic_present_n [*6]; endsequence
  sequence present_s; (!optic_present_n) [*6]; endsequence
  tx_pair_a: assert property (ir_tx_out_n == !ir_tx_out)
    else $error("transmit pair not inverse");
  tx_follow_a: assert property (tx_serial |=> ir_tx_out)
    else $error("transmit output missed serial data");
  tx_force_a: assert property (wr0 && pwdata[1] |-> ##2 ir_tx_out)
    else $error("transmit force ignored");
  off_absent_a: assert property (absent_s |-> optic_power_off)
    else $error("power-off low with no transceiver");
  off_bit_a: assert property (present_s ##0 wr0
    |-> ##2 optic_power_off == $past(pwdata[4], 2))
    else $error("power-off does not follow its bit");
  gpio_ab_a: assert property (wr0
    |-> ##2 {gpio_a, gpio_b} == $past(pwdata[7:6], 2))
    else $error("pins a and b wrong");
  gpio_cd_a: assert property (wr0
    |-> ##2 {gpio_c, gpio_d} == {$past(pwdata[5], 2), $past(pwdata[0], 2)})
    else $error("pins c and d wrong");
  det_read_a: assert property ($stable(optic_present_n) [*8]
    ##1 psel && penable && !pwrite && paddr == 8'h08
    |-> prdata[4] == optic_present_n)
    else $error("detect status bit wrong");
  reset_out_a: assert property ($rose(resetn)
    |-> !ir_tx_out && optic_power_off)
    else $error("outputs wrong after reset");
endmodule
bind ir_transceiver_pin_control ir_pin_monitor mon (.*);
`default_nettype wire

// ==== tb/optic_xcvr_model.sv ====
/* Behavioural optical transceiver.
   Assumes the bench commands attach and incoming light. */
`timescale 1ns/1ps
`default_nettype none
module optic_xcvr_model (
  // From the controller.
  input wire logic  ir_tx_out,
  input wire logic  optic_power_off,
  // Bench commands.
  input wire logic  attach,
  input wire logic  light_first,
  input wire logic  light_second,
  // To the controller.
  output logic      ir_rx_in_first,
  output logic      ir_rx_in_second,
  output logic      optic_present_n,
  output logic      fast_mode
);
  // A powered-down receiver rests at its idle high level.
  assign ir_rx_in_first  = optic_power_off | !light_first;
  assign ir_rx_in_second = optic_power_off | !light_second;
  assign optic_present_n = !attach;
  initial fast_mode = 1'b0;
  always @(negedge optic_power_off) fast_mode <= ir_tx_out;
endmodule
`default_nettype wire

// ==== tb/ir_transceiver_pin_control_bench.sv ====
/* Self-checking bench for the infrared pin control block.
   Assumes the APB slave answers with pready and the optical model. */
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_pin_control_bench;
  import ir_pin_pkg::*;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_serial = 0, attach = 0, light_first = 0, light_second = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ir_tx_out, ir_tx_out_n, optic_power_off;
  wire logic rx1, rx2, optic_present_n, gpio_a, gpio_b, gpio_c, gpio_d;
  wire logic p1, p2, fast_mode;
  int n_fail = 0, check_count = 0;
  ir_transceiver_pin_control dut (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_serial(tx_serial), .ir_tx_out(ir_tx_out),
    .ir_tx_out_n(ir_tx_out_n), .ir_rx_in_first(rx1),
    .ir_rx_in_second(rx2), .optic_power_off(optic_power_off),
    .optic_present_n(optic_present_n), .gpio_a(gpio_a), .gpio_b(gpio_b),
    .gpio_c(gpio_c), .gpio_d(gpio_d), .rx_pulse_first(p1),
    .rx_pulse_second(p2));
  optic_xcvr_model u_xcvr (.ir_tx_out(ir_tx_out),
    .optic_power_off(optic_power_off), .attach(attach),
    .light_first(light_first), .light_second(light_second),
    .ir_rx_in_first(rx1), .ir_rx_in_second(rx2),
    .optic_present_n(optic_present_n), .fast_mode(fast_mode));
  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    // Two edges so registered outputs have settled before any check.
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #1_000_000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1;
    apb(0, OFF_XCVR_CTRL, 0); check("ctl", rd, 0);
    check("off", optic_power_off, 1);
    attach <= 1;
    repeat (8) @(posedge clk_sys);
    apb(0, OFF_IR_CFG3, 0); check("det", rd[4], 0);
    check("off", optic_power_off, 0);
    for (int k = 0; k < 2; k++) begin
      apb(1, OFF_XCVR_CTRL, k ? 8'h40 : 8'hA1);
      check("gpio", {gpio_a, gpio_b, gpio_c, gpio_d},
            k ? 4'h4 : 4'hB);
    end
    apb(1, OFF_XCVR_CTRL, 8'h10); check("off", optic_power_off, 1);
    apb(1, OFF_XCVR_CTRL, 8'h12); check("tx", ir_tx_out, 1);
    check("txn", ir_tx_out_n, 0);
    apb(1, OFF_XCVR_CTRL, 8'h02); check("mode", fast_mode, 1);
    apb(1, OFF_XCVR_CTRL, 0); check("tx", ir_tx_out, 0);
    tx_serial <= 1;
    repeat (2) @(posedge clk_sys);
    check("tx", ir_tx_out, 1);
    tx_serial <= 0;
    apb(1, OFF_TX_DATA, 1); check("swtx", ir_tx_out, 1);
    apb(0, OFF_TX_DATA, 0); check("swrd", rd, 1);
    apb(1, OFF_TX_DATA, 0); check("swtx", ir_tx_out, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1, OFF_XCVR_CTRL2, i * 3);
      light_first <= 1; light_second <= 1;
      repeat (8) @(posedge clk_sys);
      check("rx", {p1, p2}, i ? 2'b00 : 2'b11);
      apb(0, OFF_RX_STATUS, 0); check("rxst", rd, i ? 0 : 3);
      light_first <= 0; light_second <= 0;
      repeat (8) @(posedge clk_sys);
      check("rx", {p1, p2}, i ? 2'b11 : 2'b00);
    end
    apb(0, 8'h20, 0); check("unmapped", rd, 0);
    check("slverr", err, 1);
    attach <= 0;
    repeat (8) @(posedge clk_sys);
    check("off", optic_power_off, 1);
    apb(0, OFF_IR_CFG3, 0); check("det", rd[4], 1);
    print_verdict;
  end
endmodule
`default_nettype wire
